// ===== shared/mpsl_pkg.sv
// Shared constants and types for the multichannel pot serial loader.
// Assumes a single core clock domain plus one serial link clock.
package mpsl_pkg;

  // ==========================================================
  // Word layout
  // ==========================================================
  localparam int ADDR_W = 3;  // Address field width
  localparam int DATA_W = 8;  // Data field width
  localparam int CHAIN_W = ADDR_W + DATA_W;  // Bits per serial word
  localparam int CH_DEFAULT = 4;  // Four-channel variant
  localparam int CH_MAX = 6;  // Six-channel variant
  localparam int QUEUE_DEPTH = 16;  // Words held between link and latches

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [DATA_W-1:0] MIDSCALE = 8'h80;  // Centred wiper code
  localparam logic [CHAIN_W-1:0] CHAIN_CLEAR = 11'h000;  // Emptied chain

  // ==========================================================
  // Carriers
  // ==========================================================
  // One serial word, address in the top bits, sent first
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mpsl_word_t;

  // One wiper setting
  typedef logic [DATA_W-1:0] mpsl_wiper_t;

endpackage

// ===== core/mpsl_fifo.sv
// Word queue between the chip-select capture and the wiper latches.
// Assumes DEPTH is a power of two; all ports on core_clk.
`timescale 1ns/1ns
module mpsl_fifo #(
  parameter int WIDTH = mpsl_pkg::CHAIN_W,
  parameter int DEPTH = mpsl_pkg::QUEUE_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic core_ce,
  input wire logic flush,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  import mpsl_pkg::*;

  // ==========================================================
  // Storage and pointers
  // ==========================================================
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);  // Count when full

  logic [WIDTH-1:0] mem [DEPTH];  // Word storage
  logic [AW-1:0] wptr;  // Next slot to write
  logic [AW-1:0] rptr;  // Oldest slot
  logic [AW:0] count;  // Words held
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign wr_ready = (count != FULL_CNT);
  assign rd_valid = (count != '0);
  assign push = wr_valid & wr_ready;
  assign pop = rd_valid & rd_ready;
  assign rd_data = mem[rptr];

  // Storage write, no reset needed for data
  always_ff @(posedge core_clk) begin
    if (core_ce && push) begin
      mem[wptr] <= wr_data;
    end
  end

  // Pointers and count; flush empties in one cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else if (core_ce) begin
      if (flush) begin
        wptr <= '0;
        rptr <= '0;
        count <= '0;
      end else begin
        if (push) begin
          wptr <= wptr + 1'b1;
        end
        if (pop) begin
          rptr <= rptr + 1'b1;
        end
        if (push && !pop) begin
          count <= count + 1'b1;
        end else if (pop && !push) begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule

// ===== core/mpsl_loader.sv
// Serial loader for a multichannel digital potentiometer.
// Assumes the host drives serial_clk, chip_sel_n and serial_in with
// setup and hold to rising serial_clk; serial_out is open drain.
// Operation
// R01 - Shift one bit per rising clock, select low
// R02 - Word: three address, eight data, MSB first
// R03 - Select rise keeps only last eleven bits
// R04 - Serial output shows bit leaving chain end
// R05 - Select rise loads addressed latch when idle
// R06 - Codes zero to five pick latches one-six
// R07 - Latch takes low eight bits per word
// R08 - Clock low leaves chain alone, output enabled
// R09 - Preset low forces midscale, clears output
// R10 - Preset rise with select high gives 0x80
// R11 - Shutdown releases output, opens top terminals
// R12 - Shutdown keeps every latch value
// R13 - Host holds select through whole daisy chain
// R14 - Host slows clock on pulled-up chain node
// R15 - Power-on presets every latch to midscale
// R16 - Select high: clock edges change nothing; code empties the chain on them while a clear is pending
// R17 - Unmatched address codes change no latch
`timescale 1ns/1ns
module mpsl_loader #(
  parameter int NUM_CH = mpsl_pkg::CH_DEFAULT,
  parameter int FIFO_DEPTH = mpsl_pkg::QUEUE_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic core_ce,
  input wire logic serial_clk,
  input wire logic chip_sel_n,
  input wire logic serial_in,
  input wire logic preset_n,
  input wire logic power_down_n,
  input wire logic update_hold,
  output logic serial_out_o,
  output logic serial_out_oe,
  output mpsl_pkg::mpsl_wiper_t [NUM_CH-1:0] wiper_latch,
  output logic top_disconnect,
  output logic queue_full,
  output logic word_dropped
);
  import mpsl_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic pr_s1;  // Preset pin, first stage
  logic pr_sync;  // Preset pin, usable level
  logic pd_s1;  // Shutdown pin, first stage
  logic pd_sync;  // Shutdown pin, usable level
  logic cs_s1;  // Select pin, first stage
  logic cs_s2;  // Select pin, usable level
  logic cs_s3;  // Select delayed for edge find
  logic cs_rise;  // Select just returned high
  logic link_clear_req;  // Core asks the link side to clear
  logic lc_s1;  // Clear request in link domain, first stage
  logic link_clear;  // Clear request, usable on serial_clk
  logic [CHAIN_W-1:0] shift_chain;  // Serial shift register
  logic drive_en;  // Output stage may pull low
  logic push_req;  // Word to queue this cycle
  logic wr_ready;  // Queue has room
  logic rd_valid;  // Queue holds a word
  logic rd_ready;  // Latches take a word
  logic pop;  // Word leaves the queue
  mpsl_word_t cap_word;  // Chain seen as a word
  mpsl_word_t upd_word;  // Word at the queue head

  // ==========================================================
  // Pin synchronisers on core_clk
  // ==========================================================
  // Preset and shutdown pins are asynchronous; two stages each
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pr_s1 <= 1'b1;
      pr_sync <= 1'b1;
      pd_s1 <= 1'b1;
      pd_sync <= 1'b1;
    end else if (core_ce) begin
      pr_s1 <= preset_n;
      pr_sync <= pr_s1;
      pd_s1 <= power_down_n;
      pd_sync <= pd_s1;
    end
  end

  // Select pin: two stages, then a third only for edge detection
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else if (core_ce) begin
      cs_s1 <= chip_sel_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  assign cs_rise = cs_s2 & ~cs_s3;

  // ==========================================================
  // Clear request toward the link domain
  // ==========================================================
  // Power-on and preset both empty the chain
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link_clear_req <= 1'b1;
    end else if (core_ce) begin
      link_clear_req <= ~pr_sync;  // [R09]
    end
  end

  // Level crossing into serial_clk; acts only while the host clocks
  always_ff @(posedge serial_clk) begin
    lc_s1 <= link_clear_req;
    link_clear <= lc_s1;
  end

  // ==========================================================
  // Link side shift chain on serial_clk
  // ==========================================================
  // Select is a link signal timed to serial_clk, so no synchroniser.
  // Falling clock edges are never seen, so a low clock leaves the
  // chain alone. [R08]
  // Shifting wins over the clear: the clear takes two link edges to
  // fall after preset release, and would otherwise eat the first bits
  // of the next frame. The clear therefore lands on idle edges only.
  always_ff @(posedge serial_clk) begin
    if (!chip_sel_n) begin
      shift_chain <= {shift_chain[CHAIN_W-2:0], serial_in};  // [R01] [R03]
    end else if (link_clear) begin
      // Idle edge with a clear pending empties the chain
      shift_chain <= CHAIN_CLEAR;  // [R09]
    end
    // Select high and no clear pending: chain holds [R16]
  end

  chk_shift_in: assert property (  // [R01]
    @(posedge serial_clk) disable iff (link_clear)
    !chip_sel_n |=> shift_chain[0] == $past(serial_in))
    else $error("chain did not take serial_in");

  // A clear still crossing over may legally empty the chain
  chk_shift_idle: assert property (  // [R16]
    @(posedge serial_clk) disable iff (link_clear || lc_s1)
    chip_sel_n |=> $stable(shift_chain))
    else $error("chain moved with select high");

  chk_shift_age: assert property (  // [R03]
    @(posedge serial_clk) disable iff (link_clear)
    (!chip_sel_n)[*2] |=> shift_chain[1] == $past(serial_in, 2))
    else $error("chain lost bit order");

  // ==========================================================
  // Open-drain serial output
  // ==========================================================
  // Output enabled only when neither preset nor shutdown is active
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      drive_en <= 1'b0;
    end else if (core_ce) begin
      drive_en <= pr_sync & pd_sync;  // [R08] [R09] [R11]
    end
  end

  // Pull low only for a zero leaving the chain; pull-up gives a one.
  // The chain bit is quasi-static between host clock edges.
  assign serial_out_o = 1'b0;
  assign serial_out_oe = drive_en & ~shift_chain[CHAIN_W-1];  // [R04] [R11]

  chk_out_bit: assert property (  // [R04]
    @(posedge core_clk) disable iff (!resetn)
    drive_en |-> serial_out_oe == ~shift_chain[CHAIN_W-1])
    else $error("serial output not chain end");

  chk_power_down_n_release: assert property (  // [R11]
    @(posedge core_clk) disable iff (!resetn)
    (core_ce && !pd_sync) |=> !serial_out_oe)
    else $error("output driven in shutdown");

  // ==========================================================
  // Capture on select rise and queue
  // ==========================================================
  // Chain is frozen once select is high, so it is read directly
  assign cap_word = mpsl_word_t'(shift_chain);  // [R02] [R03]
  assign push_req = cs_rise & pr_sync & pd_sync;  // [R05]

  // Queue ready reaches back as full flag and drop pulse
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      queue_full <= 1'b0;
      word_dropped <= 1'b0;
    end else if (core_ce) begin
      queue_full <= ~wr_ready;
      word_dropped <= push_req & ~wr_ready;
    end
  end

  chk_drop_full: assert property (  // [R05]
    @(posedge core_clk) disable iff (!resetn)
    (core_ce && push_req && !wr_ready) |=> word_dropped)
    else $error("lost word not flagged");

  chk_push_rise: assert property (  // [R05]
    @(posedge core_clk) disable iff (!resetn)
    (cs_s2 && !cs_s3 && pr_sync && pd_sync && wr_ready) |-> push_req)
    else $error("select rise not queued");

  mpsl_fifo #(
    .WIDTH(CHAIN_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .core_clk(core_clk),
    .resetn(resetn),
    .core_ce(core_ce),
    .flush(~pr_sync),
    .wr_valid(push_req),
    .wr_ready(wr_ready),
    .wr_data(cap_word),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready),
    .rd_data(upd_word)
  );

  // ==========================================================
  // Wiper latch update
  // ==========================================================
  // Shutdown and the user hold both stall the drain, so queued words
  // wait instead of changing settings while powered down.
  assign rd_ready = pr_sync & pd_sync & ~update_hold;  // [R12]
  assign pop = rd_valid & rd_ready;

  // One latch per channel; codes beyond NUM_CH match nothing
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_latch
    always_ff @(posedge core_clk) begin
      if (!resetn) begin
        wiper_latch[ch] <= MIDSCALE;  // [R15]
      end else if (core_ce) begin
        if (!pr_sync) begin
          // Held at midscale, so release leaves 0x80 behind
          wiper_latch[ch] <= MIDSCALE;  // [R09] [R10]
        end else if (pop && upd_word.addr == ADDR_W'(ch)) begin
          wiper_latch[ch] <= upd_word.data;  // [R06] [R07] [R17]
        end
      end
    end
  end

  // Resistor top terminals open while shut down
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      top_disconnect <= 1'b0;
    end else if (core_ce) begin
      top_disconnect <= ~pd_sync;  // [R11]
    end
  end

  chk_top_open: assert property (  // [R11]
    @(posedge core_clk) disable iff (!resetn)
    (core_ce && !pd_sync) |=> top_disconnect)
    else $error("top terminals not opened");

  chk_power_mid: assert property (  // [R15]
    @(posedge core_clk)
    !resetn |=> wiper_latch[0] == MIDSCALE && wiper_latch[NUM_CH-1] == MIDSCALE)
    else $error("power-on not midscale");

  chk_preset_mid: assert property (  // [R09]
    @(posedge core_clk) disable iff (!resetn)
    (core_ce && !pr_sync) |=> wiper_latch[0] == MIDSCALE
      && wiper_latch[NUM_CH-1] == MIDSCALE && !serial_out_oe)
    else $error("preset not midscale");

  chk_preset_rise: assert property (  // [R10]
    @(posedge core_clk) disable iff (!resetn)
    (core_ce && $rose(pr_sync)) |-> wiper_latch[0] == MIDSCALE)
    else $error("preset release not 0x80");

  chk_power_down_n_keep: assert property (  // [R12]
    @(posedge core_clk) disable iff (!resetn)
    (!pd_sync && pr_sync) |=> $stable(wiper_latch))
    else $error("latch changed in shutdown");

  chk_bad_addr: assert property (  // [R17]
    @(posedge core_clk) disable iff (!resetn)
    (pr_sync && pop && upd_word.addr >= ADDR_W'(NUM_CH)) |=> $stable(wiper_latch))
    else $error("unmatched code changed latch");

  chk_load_sel: assert property (  // [R06]
    @(posedge core_clk) disable iff (!resetn)
    (core_ce && pr_sync && pop && upd_word.addr == '0) |=>
      wiper_latch[0] == $past(upd_word.data))
    else $error("code zero not loaded to first latch");

  chk_load_last: assert property (  // [R07]
    @(posedge core_clk) disable iff (!resetn)
    (core_ce && pr_sync && pop && upd_word.addr == ADDR_W'(NUM_CH - 1)) |=>
      wiper_latch[NUM_CH-1] == $past(upd_word.data))
    else $error("last latch not loaded");

endmodule

// ===== dv/mpsl_host.sv
// Host model that drives the three-wire serial port of the loader.
// Assumes the bench wires pin_level as the pulled-up serial_out node.
`timescale 1ns/1ns
module mpsl_host (
  output logic serial_clk,
  output logic chip_sel_n,
  output logic serial_in,
  input wire logic pin_level
);
  // ==========================================================
  // State
  // ==========================================================
  int half = 3;  // Half period in ns; raise it for a slow chain node
  logic seen [0:31];  // Pin level after each shifting edge

  // Idle lines: clock parked low, nothing selected
  initial begin
    serial_clk = 1'b0;
    chip_sel_n = 1'b1;
    serial_in = 1'b0;
  end

  // ==========================================================
  // Idle clock pulses, select high
  // ==========================================================
  // Lets a pending chain clear land; no bit is shifted
  task automatic idle(input int n);
    repeat (n) begin
      #(half) serial_clk = 1'b1;
      #(half) serial_clk = 1'b0;
    end
  endtask

  // ==========================================================
  // One frame of n bits, MSB first
  // ==========================================================
  task automatic send(input logic [31:0] bits, input int n);
    begin
      chip_sel_n = 1'b0;  // Held low across the whole frame
      #130;  // Long enough for the core to see select low
      for (int i = n - 1; i >= 0; i--) begin
        serial_in = bits[i];  // Address first, then data, MSB first
        #(half) serial_clk = 1'b1;
        #(half) serial_clk = 1'b0;  // Slow clock when half is raised
        seen[n - 1 - i] = pin_level;
      end
      serial_in = ~serial_in;  // Released data is not the last bit
      #(half) chip_sel_n = 1'b1;
      #170;  // Select stays high with the clock stopped
    end
  endtask
endmodule

// ===== dv/multichannel_pot_serial_loader_test.sv
// Self-checking bench for the pot serial loader, four-channel build.
// Assumes the host model in mpsl_host.sv; core_ce is tied high.
`timescale 1ns/1ns
module multichannel_pot_serial_loader_test;
  import mpsl_pkg::*;
  localparam int NCH = 4;  // Channel count under test
  // ==========================================================
  // Signals
  // ==========================================================
  logic core_clk, resetn, core_ce, preset_n, power_down_n, update_hold;
  logic serial_clk, chip_sel_n, serial_in, serial_out_o, serial_out_oe;
  logic pin_level, top_disconnect, queue_full, word_dropped;
  mpsl_wiper_t [NCH-1:0] wiper_latch;
  mpsl_wiper_t [NCH-1:0] exp_w;  // Expected latch contents
  mpsl_wiper_t [NCH-1:0] prev_w;  // Latches one cycle ago
  logic [8*NCH-1:0] note_q[$];  // Expected results, oldest first
  logic [31:0] rnd, last_bits;
  int fail_count, tests_run, cycles, drops;

  assign pin_level = serial_out_oe ? serial_out_o : 1'b1;  // Pull-up node

  mpsl_loader #(.NUM_CH(NCH), .FIFO_DEPTH(16)) u_mpsl_loader (
    .core_clk(core_clk), .resetn(resetn), .core_ce(core_ce),
    .serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .serial_in(serial_in),
    .preset_n(preset_n), .power_down_n(power_down_n), .update_hold(update_hold),
    .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
    .wiper_latch(wiper_latch), .top_disconnect(top_disconnect),
    .queue_full(queue_full), .word_dropped(word_dropped));
  mpsl_host u_mpsl_host (.serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
    .serial_in(serial_in), .pin_level(pin_level));

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] next_rnd(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] want, input string msg);
    tests_run++;
    if (got !== want) begin
      $display("wrong value at %0t: %s", $time, msg);
      fail_count++;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // Random word for channel ch; apply notes the expected result
  task automatic send_word(input int ch, input bit apply, input int n);
    logic [7:0] d;
    begin
      rnd = next_rnd(rnd);
      d = rnd[7:0];
      if (apply && ch < NCH) begin
        if (d == exp_w[ch]) d = d ^ 8'h01;  // Keep every update visible
        exp_w[ch] = d;
        note_q.push_back(exp_w);
      end
      last_bits = {rnd[31:11], ch[2:0], d};
      u_mpsl_host.send(last_bits, n);
    end
  endtask

  // ==========================================================
  // Clock and watcher
  // ==========================================================
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Every latch change must match the oldest note
  always @(posedge core_clk) begin
    #1;
    if (resetn === 1'b1 && wiper_latch !== prev_w) begin
      if (note_q.size() == 0) check(32'h0, 32'h1, "unexpected latch change");
      else check(wiper_latch, note_q.pop_front(), "latch contents");
    end
    prev_w = wiper_latch;
    if (word_dropped === 1'b1) drops++;
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      final_report();
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    resetn = 1'b0;
    core_ce = 1'b1;
    preset_n = 1'b1;
    power_down_n = 1'b1;
    update_hold = 1'b0;
    rnd = 32'h5ea2c6ac;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    drops = 0;
    exp_w = {NCH{MIDSCALE}};
    // Idle link edges inside reset so the chain starts cleared
    cyc(1);
    u_mpsl_host.idle(3);
    cyc(1);
    resetn = 1'b1;
    check(wiper_latch, exp_w, "reset midscale");
    check(serial_out_oe, 1'b0, "reset pin released");
    // Every channel, then extra leading bits, then unmatched codes
    for (int ch = 0; ch < NCH; ch++) send_word(ch, 1'b1, 11);
    send_word(2, 1'b1, 14);
    for (int ch = 4; ch < 8; ch++) send_word(ch, 1'b1, 11);
    cyc(10);
    check(note_q.size(), 0, "all updates seen");
    // Two chained words on a slow clock; pin shows bit ten back
    u_mpsl_host.half = 9;
    send_word(3, 1'b1, 22);
    u_mpsl_host.half = 3;
    for (int j = 10; j < 22; j++) check(u_mpsl_host.seen[j], last_bits[31 - j], "chain out");
    // Shutdown: pin released, frame dropped, latches kept
    power_down_n = 1'b0;
    cyc(4);
    check(top_disconnect, 1'b1, "top terminals open");
    send_word(1, 1'b0, 22);
    for (int j = 0; j < 22; j++) check(u_mpsl_host.seen[j], 1'b1, "pin off");
    cyc(10);
    check(wiper_latch, exp_w, "latches kept");
    power_down_n = 1'b1;
    cyc(4);
    check(top_disconnect, 1'b0, "top terminals back");
    // Fill the queue under hold until a word is lost, then drain
    update_hold = 1'b1;
    for (int k = 0; k < 16; k++) send_word(k % NCH, 1'b1, 11);
    send_word(0, 1'b0, 11);
    check(queue_full, 1'b1, "queue full");
    check(drops, 1, "one word lost");
    update_hold = 1'b0;
    cyc(30);
    check(note_q.size(), 0, "queue drained");
    check(queue_full, 1'b0, "queue room");
    // Preset with select high forces midscale
    exp_w = {NCH{MIDSCALE}};
    note_q.push_back(exp_w);
    preset_n = 1'b0;
    cyc(6);
    check(serial_out_oe, 1'b0, "preset pin released");
    preset_n = 1'b1;
    cyc(6);
    check(wiper_latch, exp_w, "preset midscale");
    send_word(0, 1'b1, 11);
    cyc(10);
    check(note_q.size(), 0, "update after preset");
    final_report();
  end
endmodule
